/* File: core/vtg_timing.sv */
// Video timing generator: line and frame state machine, sync, blank, transfer
//
// Operation
// R1: Generate composite sync and composite blank for the video converters.
// R2: Schedule bus request, both transfer strobes, and gate both shift clocks.
// R3: Frame flyback flag is high throughout frame flyback.
// R4: Composite blank is high during frame or line flyback.
// R5: Mode inputs select interlace and television style sync.
// R6: Master drives sync pins; slave locks to external vertical and horizontal sync.
// R7: Line parameters are counts of screen units of four pixels.
// R8: Vertical parameters are counted in half line periods.
// R9: Pixels are visible only in the display segment, otherwise blanked.
// R10: No front porch count; line ends when line time expires.
// R11: Line sync is two back to back halfsync intervals.
// R12: Each state lasts its programmed count; outputs follow the current segment.
// R13: Non interlaced visible count is twice the visible lines.
// R14: Interlaced visible count describes one field in half lines.
// R15: Interlaced television frames need an odd line count.
// R16: Equalising, vsync and blank phases count half lines; their sum is flyback.
// R17: In vertical sync each half line is low for the broad pulse count.
// R18: Equalising half lines are low for the halfsync count.
// R19: Flyback shortens the loop to half a line; equalising uses short display. The code does both in tesselated sync only.
// R20: Vertical sync half lines hold only broad pulse then front porch.
// R21: Tesselated sync with equalising and serrated pulses, or plain frame sync.
// R22: Enable low halts generation; enable high starts at frame sync.
// R23: Software programs an even line time.
// R24: Sync and blank take an extra delay of zero to seven clocks.
// R25: Counters advance one screen unit per clock cycle.
`timescale 1ns/1ps
`default_nettype none

module vtg_timing
    import vtg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire vtg_mode_t mode,
    input wire vtg_line_t line_cfg,
    input wire vtg_frame_t frame_cfg,
    input wire logic vsync_n_in,
    output logic vsync_n_out,
    output logic vsync_n_oe,
    input wire logic csync_n_in,
    output logic csync_n_out,
    output logic csync_n_oe,
    output logic dac_sync_out,
    output logic composite_blank_out,
    output logic frame_flyback_flag,
    output logic bus_request_out,
    output logic [BANKS-1:0] shift_reg_transfer_strobe,
    output logic [BANKS-1:0] pixel_shift_clock_n
);

    typedef struct packed {
        vtg_seg_t seg;
        vtg_phase_t phase;
        logic [UNIT_W-1:0] pos;
        logic [UNIT_W-1:0] seg_cnt;
        logic [HL_W-1:0] vcnt;
        logic vs_meta;
        logic vs_sync;
        logic vs_prev;
        logic hs_meta;
        logic hs_sync;
        logic hs_prev;
        logic flag;
        logic bus_req;
        logic [BANKS-1:0] xfer;
        logic bank;
        logic [BANKS-1:0] shift_n;
        logic vsync_n;
        logic csync_n;
        logic pins_oe;
    } vtg_state_t;

    vtg_state_t st;
    vtg_state_t next_st;

    logic tess;
    logic flyback;
    logic eq_line;
    logic half_loop;
    logic [UNIT_W-1:0] period;
    logic [UNIT_W-1:0] seg_len;
    logic line_end;
    logic seg_done;
    logic line_sync;
    logic vs_act;
    logic dac_sync;
    logic blank_int;
    logic xfer_hit;
    logic vs_fall;
    logic hs_fall;
    vtg_video_t video_raw;
    vtg_video_t video_dly;

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [HL_W-1:0] phase_len(input vtg_phase_t ph, input vtg_frame_t f);
        case (ph)
            PH_PRE: phase_len = f.pre_equalising_count;
            PH_VSYNC: phase_len = f.vsync_count;
            PH_POST: phase_len = f.post_equalising_count;
            PH_VERTICAL_BLANK_COUNT: phase_len = f.vertical_blank_count;
            PH_DISP: phase_len = f.vertical_visible_count;
            default: phase_len = f.pre_equalising_count;
        endcase
    endfunction : phase_len

    function automatic vtg_phase_t phase_succ(input vtg_phase_t ph);
        case (ph)
            PH_PRE: phase_succ = PH_VSYNC;
            PH_VSYNC: phase_succ = PH_POST;
            PH_POST: phase_succ = PH_VERTICAL_BLANK_COUNT;
            PH_VERTICAL_BLANK_COUNT: phase_succ = PH_DISP;
            PH_DISP: phase_succ = PH_PRE;
            default: phase_succ = PH_PRE;
        endcase
    endfunction : phase_succ

    ////////////////////////////////////////////////////////////////////////
    // Decode of the current segment

    always_comb begin
        tess = (mode.sync_sel == SYNC_SEL_TESS); // R5 R21
        flyback = (st.phase != PH_DISP); // R3
        eq_line = tess && (st.phase == PH_PRE || st.phase == PH_POST);
        // Odd half line closes an interlaced field
        half_loop = (tess && flyback) // R19
            || (mode.interlace && st.phase == PH_DISP && st.vcnt == HL_HALF); // R14
        period = half_loop ? (line_cfg.line_time >> 1) : line_cfg.line_time; // R7 R10
        line_end = (st.pos == period - UNIT_ONE); // R25
        case (st.seg)
            SEG_HSYNC1: seg_len = line_cfg.halfsync; // R11
            SEG_HSYNC2: seg_len = line_cfg.halfsync; // R11
            SEG_BACK: seg_len = line_cfg.back_porch;
            SEG_DISP: seg_len = eq_line ? line_cfg.short_display : line_cfg.display; // R19
            SEG_BROAD: seg_len = line_cfg.broad_pulse; // R17
            default: seg_len = UNIT_MAX;
        endcase
        seg_done = (st.seg != SEG_FRONT) && (st.seg_cnt == seg_len - UNIT_ONE); // R12
        // Equalising lines keep only the first half of line sync
        line_sync = (st.seg == SEG_HSYNC1) // R18
            || (st.seg == SEG_HSYNC2 && !eq_line) // R11
            || (st.seg == SEG_BROAD); // R17
        vs_act = (st.phase == PH_VSYNC);
        dac_sync = tess ? line_sync : (line_sync || vs_act); // R1
        blank_int = flyback || (st.seg != SEG_DISP) || !mode.enable; // R4 R9
        xfer_hit = st.bus_req && st.phase == PH_DISP && st.seg == SEG_BACK
            && st.seg_cnt == line_cfg.transfer_delay; // R2
        vs_fall = mode.slave && st.vs_prev && !st.vs_sync; // R6
        hs_fall = mode.slave && st.hs_prev && !st.hs_sync; // R6
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        vtg_phase_t nph;
        logic [HL_W-1:0] dec;
        nph = st.phase;
        dec = half_loop ? HL_HALF : HL_FULL; // R8
        next_st = st;

        // Pins sampled twice before use; slow external edges only
        next_st.vs_meta = vsync_n_in;
        next_st.vs_sync = st.vs_meta;
        next_st.vs_prev = st.vs_sync;
        next_st.hs_meta = csync_n_in;
        next_st.hs_sync = st.hs_meta;
        next_st.hs_prev = st.hs_sync;

        if (!mode.enable) begin
            // Parked at frame sync start so parameters can be rewritten
            next_st.phase = PH_PRE; // R22
            next_st.vcnt = frame_cfg.pre_equalising_count; // R22
            next_st.pos = UNIT_ZERO; // R22
            next_st.seg_cnt = UNIT_ZERO;
            next_st.seg = tess ? SEG_HSYNC1 : SEG_HSYNC1;
            next_st.bus_req = 1'b0;
        end else if (vs_fall || line_end || hs_fall) begin
            if (vs_fall) begin
                nph = PH_VSYNC; // R6
                next_st.vcnt = frame_cfg.vsync_count;
            end else begin
                // External line start counts as a line end in slave
                if (st.vcnt <= dec) begin
                    nph = phase_succ(st.phase); // R16
                    next_st.vcnt = phase_len(nph, frame_cfg); // R13
                end else begin
                    next_st.vcnt = st.vcnt - dec; // R8
                end
            end
            next_st.phase = nph;
            next_st.pos = UNIT_ZERO; // R10
            next_st.seg_cnt = UNIT_ZERO;
            next_st.seg = (tess && nph == PH_VSYNC) ? SEG_BROAD : SEG_HSYNC1; // R20
            next_st.bus_req = 1'b0;
        end else begin
            next_st.pos = st.pos + UNIT_ONE; // R25
            if (seg_done) begin
                next_st.seg_cnt = UNIT_ZERO; // R12
                case (st.seg)
                    SEG_HSYNC1: next_st.seg = SEG_HSYNC2; // R11
                    SEG_HSYNC2: next_st.seg = SEG_BACK;
                    SEG_BACK: next_st.seg = SEG_DISP;
                    SEG_DISP: next_st.seg = SEG_FRONT; // R10
                    SEG_BROAD: next_st.seg = SEG_FRONT; // R20
                    default: next_st.seg = SEG_FRONT;
                endcase
            end else begin
                next_st.seg_cnt = st.seg_cnt + UNIT_ONE;
            end
            // Request the bus ahead of each visible line
            if (seg_done && st.seg == SEG_HSYNC2 && st.phase == PH_DISP) begin
                next_st.bus_req = 1'b1; // R2
            end else if (xfer_hit) begin
                next_st.bus_req = 1'b0; // R2
            end
        end

        next_st.flag = mode.enable ? (next_st.phase != PH_DISP) : 1'b1; // R3

        // Transfer loads the idle bank, which then shifts this line
        next_st.xfer = '0;
        if (xfer_hit) begin
            next_st.xfer[~st.bank] = 1'b1; // R2
            next_st.bank = ~st.bank;
        end
        for (int b = 0; b < BANKS; b++) begin
            if (mode.enable && st.phase == PH_DISP && st.seg == SEG_DISP
                && b == int'(st.bank)) begin
                next_st.shift_n[b] = ~st.shift_n[b]; // R2 R9
            end else begin
                next_st.shift_n[b] = 1'b1; // R2
            end
        end

        // Pins in master mode only; slave leaves them to the sync source
        next_st.pins_oe = !mode.slave; // R6
        next_st.vsync_n = !(vs_act && mode.enable); // R6
        if (mode.sync_sel[SYNC_SEL_HSYNC_BIT]) begin
            next_st.csync_n = !(line_sync && mode.enable);
        end else if (mode.sync_sel == SYNC_SEL_PLAIN) begin
            next_st.csync_n = !((line_sync || vs_act) && mode.enable);
        end else begin
            next_st.csync_n = !(line_sync && mode.enable); // R21
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.seg <= SEG_HSYNC1;
            st.phase <= PH_PRE;
            st.vs_meta <= 1'b1;
            st.vs_sync <= 1'b1;
            st.vs_prev <= 1'b1;
            st.hs_meta <= 1'b1;
            st.hs_sync <= 1'b1;
            st.hs_prev <= 1'b1;
            st.flag <= 1'b1;
            st.shift_n <= '1;
            st.vsync_n <= 1'b1;
            st.csync_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delayed converter sync and blank

    always_comb begin
        video_raw.csync = dac_sync && mode.enable; // R1
        video_raw.blank = blank_int; // R4
    end

    vtg_delay #(
        .DEPTH(DLY_DEPTH)
    ) u_delay (
        .clk(clk),
        .rst(rst),
        .din(video_raw),
        .sel(mode.pipe_delay),
        .dout(video_dly)
    );

    assign dac_sync_out = video_dly.csync; // R24
    assign composite_blank_out = video_dly.blank; // R24
    assign frame_flyback_flag = st.flag;
    assign bus_request_out = st.bus_req;
    assign shift_reg_transfer_strobe = st.xfer;
    assign pixel_shift_clock_n = st.shift_n;
    assign vsync_n_out = st.vsync_n;
    assign vsync_n_oe = st.pins_oe;
    assign csync_n_out = st.csync_n;
    assign csync_n_oe = st.pins_oe;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_hsync1_ends;
        (st.seg == SEG_HSYNC1) ##1 (st.seg == SEG_HSYNC2);
    endsequence

    sequence s_broad_ends;
        (st.seg == SEG_BROAD) ##1 (st.seg == SEG_FRONT);
    endsequence

    a_blank_flyback: assert property ((mode.pipe_delay == '0 && flyback) // R4
        |=> composite_blank_out)
        else $error("blank low during frame flyback");

    a_blank_visible: assert property ((mode.pipe_delay == '0 && st.seg != SEG_DISP) // R9
        |=> composite_blank_out)
        else $error("blank low outside display segment");

    a_flag_tracks: assert property (mode.enable && $stable(mode.enable) // R3
        |-> frame_flyback_flag == flyback)
        else $error("flyback flag disagrees with phase");

    a_halfsync_len: assert property (s_hsync1_ends |-> // R11
        $past(st.seg_cnt) == line_cfg.halfsync - UNIT_ONE)
        else $error("first sync half has wrong length");

    a_broad_len: assert property (s_broad_ends |-> // R17
        $past(st.seg_cnt) == line_cfg.broad_pulse - UNIT_ONE)
        else $error("broad pulse has wrong length");

    a_vsync_order: assert property ((st.seg == SEG_BROAD) |=> // R20
        (st.seg == SEG_BROAD || st.seg == SEG_FRONT || st.seg == SEG_HSYNC1))
        else $error("vertical sync half line left broad pulse wrongly");

    a_half_loop: assert property (mode.enable && !mode.slave && tess && flyback // R19
        && st.pos == (line_cfg.line_time >> 1) - UNIT_ONE |=> st.pos == UNIT_ZERO)
        else $error("flyback loop is not half a line");

    a_park_frame: assert property (!mode.enable |=> // R22
        (st.phase == PH_PRE && st.pos == UNIT_ZERO && st.seg == SEG_HSYNC1))
        else $error("disabled generator not parked at frame sync");

    a_xfer_pulse: assert property ((shift_reg_transfer_strobe != '0) |-> // R2
        !bus_request_out ##1 (shift_reg_transfer_strobe == '0))
        else $error("transfer strobe not a single cycle");

    a_master_vsync: assert property (mode.enable && !mode.slave && vs_act // R6
        && $stable(mode) |=> (vsync_n_oe && !vsync_n_out))
        else $error("master vertical sync pin not driven low");

endmodule : vtg_timing

`default_nettype wire

/* File: core/vtg_pkg.sv */
// Shared constants and types of the video timing generator
package vtg_pkg;

    localparam int UNIT_W = 12;
    localparam int HL_W = 12;
    localparam int DLY_W = 3;
    localparam int DLY_DEPTH = 8;
    localparam int BANKS = 2;

    localparam logic [1:0] SYNC_SEL_TESS = 2'h0;
    localparam logic [1:0] SYNC_SEL_PLAIN = 2'h1;
    localparam int SYNC_SEL_HSYNC_BIT = 1;

    localparam logic [HL_W-1:0] HL_HALF = 12'h001;
    localparam logic [HL_W-1:0] HL_FULL = 12'h002;
    localparam logic [UNIT_W-1:0] UNIT_ONE = 12'h001;
    localparam logic [UNIT_W-1:0] UNIT_ZERO = 12'h000;
    localparam logic [UNIT_W-1:0] UNIT_MAX = 12'hFFF;

    typedef enum logic [2:0] {
        SEG_HSYNC1 = 3'h0,
        SEG_HSYNC2 = 3'h1,
        SEG_BACK = 3'h2,
        SEG_DISP = 3'h3,
        SEG_FRONT = 3'h4,
        SEG_BROAD = 3'h5
    } vtg_seg_t;

    typedef enum logic [2:0] {
        PH_PRE = 3'h0,
        PH_VSYNC = 3'h1,
        PH_POST = 3'h2,
        PH_VERTICAL_BLANK_COUNT = 3'h3,
        PH_DISP = 3'h4
    } vtg_phase_t;

    typedef struct packed {
        logic enable;
        logic interlace;
        logic slave;
        logic [1:0] sync_sel;
        logic [DLY_W-1:0] pipe_delay;
    } vtg_mode_t;

    typedef struct packed {
        logic [UNIT_W-1:0] halfsync;
        logic [UNIT_W-1:0] back_porch;
        logic [UNIT_W-1:0] display;
        logic [UNIT_W-1:0] short_display;
        logic [UNIT_W-1:0] broad_pulse;
        logic [UNIT_W-1:0] line_time;
        logic [UNIT_W-1:0] transfer_delay;
    } vtg_line_t;

    typedef struct packed {
        logic [HL_W-1:0] pre_equalising_count;
        logic [HL_W-1:0] vsync_count;
        logic [HL_W-1:0] post_equalising_count;
        logic [HL_W-1:0] vertical_blank_count;
        logic [HL_W-1:0] vertical_visible_count;
    } vtg_frame_t;

    typedef struct packed {
        logic csync;
        logic blank;
    } vtg_video_t;

endpackage : vtg_pkg

/* File: core/vtg_delay.sv */
// Programmable pipeline delay for internal sync and blank
`timescale 1ns/1ps
`default_nettype none

module vtg_delay
    import vtg_pkg::*;
#(
    parameter int DEPTH = DLY_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire vtg_video_t din,
    input wire logic [DLY_W-1:0] sel,
    output var vtg_video_t dout
);

    typedef struct packed {
        vtg_video_t [DEPTH-1:0] taps;
        vtg_video_t out;
    } vtg_dly_state_t;

    vtg_dly_state_t st;
    vtg_dly_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.taps[0] = din;
        for (int i = 1; i < DEPTH; i++) begin
            next_st.taps[i] = st.taps[i-1];
        end
        // Zero extra delay still costs the output flop
        next_st.out = (sel == '0) ? din : st.taps[sel - 1'b1]; // R24
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.out;

    a_delay_zero: assert property (@(posedge clk) disable iff (rst) // R24
        (sel == '0) |=> (dout == $past(din)))
        else $error("zero delay tap does not follow input");

endmodule : vtg_delay

`default_nettype wire

/* File: test/vtg_sync_master.sv */
// External sync source that the generator locks to in slave operation
`timescale 1ns/1ps
`default_nettype none

module vtg_sync_master
    import vtg_pkg::*;
#(
    parameter int LINE = 60,
    parameter int FRAME = 3000,
    parameter int PULSE = 6
) (
    input wire logic clk,
    input wire logic run,
    output logic csync_n,
    output logic vsync_n
);
    int pos_l;
    int pos_f;

    always_ff @(posedge clk) begin
        if (!run) begin
            pos_l <= 0;
            pos_f <= 0;
        end else begin
            pos_l <= (pos_l == LINE - 1) ? 0 : pos_l + 1;
            pos_f <= (pos_f == FRAME - 1) ? 0 : pos_f + 1;
        end
    end

    // Stopped source drives both pins high, as pull-ups would
    assign csync_n = !(run && pos_l < PULSE);
    assign vsync_n = !(run && pos_f < LINE);
endmodule : vtg_sync_master

`default_nettype wire

/* File: test/video_timing_generator_tb.sv */
// Self-checking bench of the video timing generator
`timescale 1ns/1ps
`default_nettype none

module video_timing_generator_tb;
    import vtg_pkg::*;
    localparam int HS = 3;
    localparam int BP = 20;
    localparam int DSP = 30;
    localparam int LT = 80;
    localparam int EQ = 2;
    localparam int VS = 2;
    localparam int VB = 4;
    localparam int VIS = 10;
    localparam int FB = (2 * EQ + VS + VB) * LT / 2;
    localparam int FR = FB + VIS * LT / 2;
    typedef struct {
        logic [1:0] sel;
        logic [2:0] dly;
        int n6;
        int n3;
        int n36;
        int n80;
    } vtg_row_t;
    logic clk;
    logic rst;
    logic vsync_n_in, vsync_n_out, vsync_n_oe, csync_n_in, csync_n_out, csync_n_oe;
    logic dac_sync_out, composite_blank_out, frame_flyback_flag, bus_request_out;
    logic [BANKS-1:0] shift_reg_transfer_strobe;
    logic [BANKS-1:0] pixel_shift_clock_n;
    logic src_run, src_vs_n, src_cs_n;
    vtg_mode_t mode;
    vtg_line_t line_cfg;
    vtg_frame_t frame_cfg;
    int fail_count, n_compared, base;
    vtg_row_t rows [4] = '{'{2'h2, 3'h0, FR / LT, 0, 0, FR / LT - 1},
        '{2'h0, 3'h3, VB + VIS / 2, 2 * EQ, VS, -1},
        '{2'h3, 3'h7, FR / LT, 0, 0, FR / LT - 1}, '{2'h1, 3'h0, -1, 0, 0, -1}};

    // Released pins follow the external sync source, which idles high when stopped
    assign vsync_n_in = vsync_n_oe ? vsync_n_out : src_vs_n;
    assign csync_n_in = csync_n_oe ? csync_n_out : src_cs_n;

    vtg_timing u_vtg_timing (.clk(clk), .rst(rst), .mode(mode), .line_cfg(line_cfg),
        .frame_cfg(frame_cfg), .vsync_n_in(vsync_n_in), .vsync_n_out(vsync_n_out),
        .vsync_n_oe(vsync_n_oe), .csync_n_in(csync_n_in), .csync_n_out(csync_n_out),
        .csync_n_oe(csync_n_oe), .dac_sync_out(dac_sync_out),
        .composite_blank_out(composite_blank_out), .frame_flyback_flag(frame_flyback_flag),
        .bus_request_out(bus_request_out), .shift_reg_transfer_strobe(shift_reg_transfer_strobe),
        .pixel_shift_clock_n(pixel_shift_clock_n));
    vtg_sync_master u_vtg_sync_master (.clk(clk), .run(src_run), .csync_n(src_cs_n),
        .vsync_n(src_vs_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    task cmp_int(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_int

    task step;
        @(posedge clk);
        #1;
    endtask : step

    function automatic logic pick(input int s);
        case (s)
            0: return vsync_n_out;
            1: return frame_flyback_flag;
            2: return composite_blank_out;
            3: return dac_sync_out;
            default: return csync_n_out;
        endcase
    endfunction : pick

    // Bounded wait; a hang ends the run as a mismatch
    task wait_lvl(input int s, input logic v, output int k);
        k = 0;
        while (pick(s) !== v) begin
            if (k == 4000) begin
                fail_count++;
                complete_run();
            end
            step();
            k++;
        end
    endtask : wait_lvl

    task set_mode(input logic [1:0] sel, input logic [2:0] dly, input logic slv);
        mode.enable = 1'b0;
        step();
        step();
        mode.sync_sel = sel;
        mode.pipe_delay = dly;
        mode.slave = slv;
        step();
        mode.enable = 1'b1;
    endtask : set_mode

    task run_row(input vtg_row_t r, input int idx);
        int k, lag, fb, bk, st, w, n6, n3, n36, n80, last;
        set_mode(r.sel, r.dly, 1'b0);
        step();
        wait_lvl(1, 1'b0, k);
        if (idx == 0) cmp_bit(k >= FB - 1 && k <= FB + 3, 1'b1);
        wait_lvl(2, 1'b0, lag);
        if (idx == 0) base = lag;
        cmp_int(lag, base + int'(r.dly));
        wait_lvl(0, 1'b0, k);
        wait_lvl(0, 1'b1, k);
        repeat (20) step();
        {fb, bk, st, w, n6, n3, n36, n80} = '0;
        last = -1;
        for (int i = 0; i < FR; i++) begin
            fb += (frame_flyback_flag === 1'b1);
            bk += (composite_blank_out === 1'b1);
            st += (shift_reg_transfer_strobe !== 2'h0);
            if (csync_n_out === 1'b0) begin
                if (w == 0 && last >= 0 && i - last == LT) n80++;
                if (w == 0) last = i;
                w++;
            end else begin
                n6 += (w == 2 * HS);
                n3 += (w == HS);
                n36 += (w == LT / 2 - 4);
                w = 0;
            end
            step();
        end
        cmp_bit(vsync_n_oe & csync_n_oe, 1'b1);
        cmp_int(fb, FB);
        cmp_int(bk, FB + VIS / 2 * (LT - DSP));
        cmp_int(st, VIS / 2);
        if (r.n6 >= 0) cmp_int(n6, r.n6);
        cmp_int(n3, r.n3);
        cmp_int(n36, r.n36);
        if (r.n80 >= 0) cmp_int(n80, r.n80);
    endtask : run_row

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k, g1, g2;
        fail_count = 0;
        n_compared = 0;
        base = 0;
        rst = 1'b1;
        src_run = 1'b0;
        mode = '0;
        line_cfg = '{12'(HS), 12'(BP), 12'(DSP), 12'h00A, 12'(LT / 2 - 4), 12'(LT), 12'h005};
        frame_cfg = '{12'(EQ), 12'(VS), 12'(EQ), 12'(VB), 12'(VIS)};
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        cmp_bit(frame_flyback_flag, 1'b1);
        cmp_bit(bus_request_out | vsync_n_oe | csync_n_oe, 1'b0);
        cmp_int(32'(shift_reg_transfer_strobe), 0);
        cmp_int(32'(pixel_shift_clock_n), 3);
        cmp_bit(vsync_n_out & csync_n_out, 1'b1);
        // Idle generator blanks from the first edge after reset
        step();
        cmp_bit(frame_flyback_flag & composite_blank_out, 1'b1);
        cmp_bit(vsync_n_oe & csync_n_oe, 1'b1);
        foreach (rows[i]) run_row(rows[i], i);
        // Disabled generator blanks and idles sync
        mode.enable = 1'b0;
        repeat (12) step();
        cmp_bit(composite_blank_out & frame_flyback_flag, 1'b1);
        cmp_bit(dac_sync_out, 1'b0);
        cmp_bit(vsync_n_out, 1'b1);
        // Slave: external lines shorter than line time force the period
        src_run = 1'b1;
        set_mode(2'h2, 3'h0, 1'b1);
        repeat (50) step();
        cmp_bit(vsync_n_oe | csync_n_oe, 1'b0);
        wait_lvl(1, 1'b0, k);
        wait_lvl(3, 1'b0, k);
        wait_lvl(3, 1'b1, k);
        wait_lvl(3, 1'b0, g1);
        wait_lvl(3, 1'b1, g2);
        cmp_int(g1 + g2, 60);
        wait_lvl(3, 1'b0, g1);
        wait_lvl(3, 1'b1, g2);
        cmp_int(g1 + g2, 60);
        complete_run();
    end
endmodule : video_timing_generator_tb

`default_nettype wire
